// file: hw/pld_div.sv
/*
 * Restoring unsigned divider, one quotient bit per clock.
 * Assumes start is a one-cycle pulse while idle and divisor is non-zero.
 */
`timescale 1ns/1ps
module pld_div #(
    parameter int W = 19
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic start,
    input wire logic [W-1:0] dividend,
    input wire logic [W-1:0] divisor,
    output logic [W-1:0] quotient,
    output logic [W-1:0] remainder,
    output logic done
);
    localparam int CW = $clog2(W + 1);

    logic [W-1:0] quo_ff;
    logic [W-1:0] rem_ff;
    logic [W-1:0] div_ff;
    logic [CW-1:0] cnt_ff;
    logic busy_ff;
    logic done_ff;
    logic [W:0] shifted;
    logic [W:0] trial;

    assign shifted = {rem_ff, quo_ff[W-1]};
    assign trial = shifted - {1'b0, div_ff};

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            quo_ff <= '0;
            rem_ff <= '0;
            div_ff <= '0;
            cnt_ff <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (start && !busy_ff) begin
                quo_ff <= dividend;
                rem_ff <= '0;
                div_ff <= divisor;
                cnt_ff <= CW'(W);
                busy_ff <= 1'b1;
            end else if (busy_ff) begin
                if (!trial[W]) begin
                    rem_ff <= trial[W-1:0];
                    quo_ff <= {quo_ff[W-2:0], 1'b1};
                end else begin
                    rem_ff <= shifted[W-1:0];
                    quo_ff <= {quo_ff[W-2:0], 1'b0};
                end
                cnt_ff <= cnt_ff - 1'b1;
                if (cnt_ff == CW'(1)) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end
            end
        end
    end

    assign quotient = quo_ff;
    assign remainder = rem_ff;
    assign done = done_ff;

endmodule

// file: hw/pld_pkg.sv
/*
 * Package for the power-loss controlled deceleration sequencer:
 * widths, register offsets, field positions, reset values, timing and states.
 * Assumes a 40 MHz control clock and setting units of 0.1 V, 0.01 Hz, 0.01 s.
 */
package pld_pkg;

    // ----------------------------------------------------------------
    // widths and ranges
    // ----------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int VOLT_W = 14;
    localparam int FREQ_W = 16;
    localparam int TIME_W = 19;
    localparam int STEP_W = 10;
    localparam int EV_W = 4;
    localparam int EN_W = 2;

    localparam logic [31:0] VOLT_MAX = 32'h0000_2710;
    localparam logic [31:0] STEP_MAX = 32'h0000_03e8;
    localparam logic [31:0] TIME_MIN = 32'h0000_0001;
    localparam logic [31:0] TIME_MAX = 32'h0005_7e40;
    localparam logic [31:0] ZERO_32 = 32'h0000_0000;

    // ----------------------------------------------------------------
    // enable codes
    // ----------------------------------------------------------------
    localparam logic [EN_W-1:0] ENABLE_OFF = 2'h0;
    localparam logic [EN_W-1:0] ENABLE_ON = 2'h1;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
    localparam logic [ADDR_W-1:0] OFF_TRIG = 6'h04;
    localparam logic [ADDR_W-1:0] OFF_OVLV = 6'h08;
    localparam logic [ADDR_W-1:0] OFF_TIME = 6'h0c;
    localparam logic [ADDR_W-1:0] OFF_STEP = 6'h10;
    localparam logic [ADDR_W-1:0] OFF_STAT = 6'h14;
    localparam logic [ADDR_W-1:0] OFF_MASK = 6'h18;
    localparam logic [ADDR_W-1:0] OFF_MON = 6'h1c;

    // ----------------------------------------------------------------
    // monitor fields and event bits
    // ----------------------------------------------------------------
    localparam int MON_STATE_LSB = 16;
    localparam int MON_PAUSE_BIT = 18;
    localparam int MON_DRIVE_BIT = 19;
    localparam int EV_START = 0;
    localparam int EV_PAUSE = 1;
    localparam int EV_UV = 2;
    localparam int EV_DONE = 3;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [VOLT_W-1:0] TRIG_RST = 14'h0000;
    localparam logic [VOLT_W-1:0] OVLV_RST = 14'h0000;
    localparam logic [TIME_W-1:0] TIME_RST = 19'h00064;
    localparam logic [STEP_W-1:0] STEP_RST = 10'h000;
    localparam logic [EV_W-1:0] MASK_RST = 4'h0;

    // ----------------------------------------------------------------
    // timing: ramp time unit is 10 ms
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_TIME_NS = 10000000;
    localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PLD_ST_NORMAL = 2'b00,
        PLD_ST_DIVIDE = 2'b01,
        PLD_ST_RAMP = 2'b10,
        PLD_ST_HALT = 2'b11
    } pld_state_t;

endpackage

// file: hw/pld_top.sv
/*
 * Power-loss controlled deceleration sequencer with register port and interrupt.
 * Assumes bus_volt and freq_ref come from logic on the same clock; the power-ok
 * and under-voltage lines are pins and are synchronised here.
 */
//
// Operation
// R01: disabled, power loss shuts output off at once; motor coasts.
// R02: enable field: code 00 off, code 01 on.
// R03: enabled, start stop when bus voltage decays to trigger level.
// R04: at start, drop output frequency once by the initial step.
// R05: then ramp linearly over the dedicated power-loss ramp time.
// R06: hold frequency while bus voltage is above the pause level.
// R07: resume the ramp once bus voltage falls back below it.
// R08: pause and resume repeatedly until under-voltage ends the sequence.
// R09: started stop runs to standstill even if power returns.
// R10: power back and stop complete, return to run-capable mode.
// R11: software sets pause level above the trigger level.
// R12: enable changes power-fail and under-voltage indication outputs.
// R13: slope takes post-step frequency to zero over ramp time, pauses excluded.
`timescale 1ns/1ps
module pld_top #(
    parameter int TICK_CYCLES_P = pld_pkg::TICK_CYCLES
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [pld_pkg::ADDR_W-1:0] addr,
    input wire logic [pld_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [pld_pkg::DATA_W-1:0] rdata,
    input wire logic [pld_pkg::FREQ_W-1:0] freq_ref,
    input wire logic [pld_pkg::VOLT_W-1:0] bus_volt,
    input wire logic power_ok_pin,
    input wire logic uv_pin,
    output logic [pld_pkg::FREQ_W-1:0] freq_out,
    output logic drive_en,
    output logic decel_active,
    output logic ramp_paused,
    output logic run_permit,
    output logic pf_ind,
    output logic uv_ind,
    output logic irq
);
    import pld_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES_P + 1);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] clamp(input logic [31:0] v, lo, hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic [FREQ_W-1:0] sat_sub(input logic [FREQ_W-1:0] a,
        input logic [FREQ_W:0] b);
        return ({1'b0, a} > b) ? a - b[FREQ_W-1:0] : '0;
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic pok_s1_ff;
    logic pok_s2_ff;
    logic uv_s1_ff;
    logic uv_s2_ff;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pok_s1_ff <= 1'b0;
            pok_s2_ff <= 1'b0;
            uv_s1_ff <= 1'b0;
            uv_s2_ff <= 1'b0;
        end else begin
            pok_s1_ff <= power_ok_pin;
            pok_s2_ff <= pok_s1_ff;
            uv_s1_ff <= uv_pin;
            uv_s2_ff <= uv_s1_ff;
        end
    end

    // ----------------------------------------------------------------
    // settings registers
    // ----------------------------------------------------------------
    logic [EN_W-1:0] enable_ff;
    logic [VOLT_W-1:0] trig_ff;
    logic [VOLT_W-1:0] ovlv_ff;
    logic [TIME_W-1:0] time_ff;
    logic [STEP_W-1:0] step_ff;
    logic [EV_W-1:0] mask_ff;
    logic [EV_W-1:0] status_ff;
    logic [EV_W-1:0] ev_ff;
    logic [EV_W-1:0] nxt_status;
    logic enabled;

    assign enabled = (enable_ff == ENABLE_ON); // see R02

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            enable_ff <= ENABLE_OFF;
            trig_ff <= TRIG_RST;
            ovlv_ff <= OVLV_RST;
            time_ff <= TIME_RST;
            step_ff <= STEP_RST;
            mask_ff <= MASK_RST;
        end else if (wr) begin
            unique case (addr)
                OFF_CTRL: enable_ff <= wdata[EN_W-1:0]; // see R02
                OFF_TRIG: trig_ff <= VOLT_W'(clamp(wdata, ZERO_32, VOLT_MAX)); // see R03
                OFF_OVLV: ovlv_ff <= VOLT_W'(clamp(wdata, ZERO_32, VOLT_MAX)); // see R06
                OFF_TIME: time_ff <= TIME_W'(clamp(wdata, TIME_MIN, TIME_MAX)); // see R05
                OFF_STEP: step_ff <= STEP_W'(clamp(wdata, ZERO_32, STEP_MAX)); // see R04
                OFF_MASK: mask_ff <= wdata[EV_W-1:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // sticky status and interrupt; a new event beats a clear
    // ----------------------------------------------------------------
    always_comb begin
        nxt_status = status_ff;
        if (wr && addr == OFF_STAT) begin
            nxt_status = status_ff & ~wdata[EV_W-1:0];
        end
        nxt_status = nxt_status | ev_ff;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            status_ff <= '0;
            irq <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            irq <= |(nxt_status & mask_ff);
        end
    end

    // ----------------------------------------------------------------
    // ramp slope divider
    // ----------------------------------------------------------------
    logic div_start_ff;
    logic div_done;
    logic [TIME_W-1:0] div_q;
    logic [TIME_W-1:0] div_r;

    pld_div #(
        .W(TIME_W)
    ) u_div (
        .clock(clock),
        .rstn(rstn),
        .start(div_start_ff),
        .dividend(TIME_W'(freq_out)),
        .divisor(time_ff),
        .quotient(div_q),
        .remainder(div_r),
        .done(div_done)
    );

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    pld_state_t state_ff;
    logic [FREQ_W-1:0] q_ff;
    logic [TIME_W-1:0] r_ff;
    logic [TIME_W-1:0] acc_ff;
    logic [TW-1:0] tick_ff;
    logic power_lost;
    logic trigger;
    logic over;
    logic tick;
    logic [TIME_W:0] acc_sum;
    logic carry;

    assign power_lost = !pok_s2_ff;
    assign trigger = enabled && power_lost && (bus_volt <= trig_ff); // see R03
    assign over = bus_volt > ovlv_ff; // see R06
    assign tick = (tick_ff == TW'(TICK_CYCLES_P - 1));
    assign acc_sum = {1'b0, acc_ff} + {1'b0, r_ff};
    assign carry = acc_sum >= {1'b0, time_ff};

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_ff <= PLD_ST_NORMAL;
            freq_out <= '0;
            drive_en <= 1'b0;
            ramp_paused <= 1'b0;
            div_start_ff <= 1'b0;
            q_ff <= '0;
            r_ff <= '0;
            acc_ff <= '0;
            tick_ff <= '0;
            ev_ff <= '0;
        end else begin
            div_start_ff <= 1'b0;
            ev_ff <= '0;
            unique case (state_ff)
                PLD_ST_NORMAL: begin
                    ramp_paused <= 1'b0;
                    if (trigger) begin
                        freq_out <= sat_sub(freq_out, (FREQ_W + 1)'(step_ff)); // see R04
                        div_start_ff <= 1'b1; // see R13
                        ev_ff[EV_START] <= 1'b1;
                        state_ff <= PLD_ST_DIVIDE;
                    end else if (power_lost && (!enabled || uv_s2_ff)) begin
                        drive_en <= 1'b0; // see R01
                        freq_out <= '0;
                    end else if (!power_lost) begin
                        drive_en <= 1'b1;
                        freq_out <= freq_ref;
                    end
                end
                PLD_ST_DIVIDE: begin
                    if (uv_s2_ff) begin
                        drive_en <= 1'b0;
                        freq_out <= '0;
                        ev_ff[EV_UV] <= 1'b1;
                        state_ff <= PLD_ST_HALT;
                    end else if (div_done) begin
                        q_ff <= div_q[FREQ_W-1:0]; // see R13
                        r_ff <= div_r;
                        acc_ff <= '0;
                        tick_ff <= '0;
                        state_ff <= PLD_ST_RAMP;
                    end
                end
                PLD_ST_RAMP: begin
                    ramp_paused <= over; // see R06
                    if (over && !ramp_paused) begin
                        ev_ff[EV_PAUSE] <= 1'b1;
                    end
                    if (uv_s2_ff) begin
                        drive_en <= 1'b0; // see R08
                        freq_out <= '0;
                        ramp_paused <= 1'b0;
                        ev_ff[EV_UV] <= 1'b1;
                        state_ff <= PLD_ST_HALT;
                    end else if (freq_out == '0) begin
                        drive_en <= 1'b0; // see R09
                        ramp_paused <= 1'b0;
                        ev_ff[EV_DONE] <= 1'b1;
                        state_ff <= PLD_ST_HALT;
                    end else if (!over) begin
                        // paused time holds the tick count, so it is not spent
                        if (tick) begin
                            tick_ff <= '0;
                            if (carry) begin
                                acc_ff <= TIME_W'(acc_sum - {1'b0, time_ff});
                                freq_out <= sat_sub(freq_out, {1'b0, q_ff} + 1'b1); // see R05
                            end else begin
                                acc_ff <= acc_sum[TIME_W-1:0];
                                freq_out <= sat_sub(freq_out, {1'b0, q_ff}); // see R13
                            end
                        end else begin
                            tick_ff <= tick_ff + 1'b1; // see R07
                        end
                    end
                end
                PLD_ST_HALT: begin
                    freq_out <= '0;
                    drive_en <= 1'b0;
                    if (!power_lost) begin
                        state_ff <= PLD_ST_NORMAL; // see R10
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // indications
    // ----------------------------------------------------------------
    logic in_seq;

    assign in_seq = (state_ff == PLD_ST_DIVIDE) || (state_ff == PLD_ST_RAMP);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            decel_active <= 1'b0;
            run_permit <= 1'b0;
            pf_ind <= 1'b0;
            uv_ind <= 1'b0;
        end else begin
            decel_active <= in_seq;
            run_permit <= (state_ff == PLD_ST_NORMAL) && !power_lost; // see R10
            if (enabled) begin
                pf_ind <= (state_ff != PLD_ST_NORMAL); // see R12
                uv_ind <= uv_s2_ff && !in_seq;
            end else begin
                pf_ind <= power_lost; // see R12
                uv_ind <= uv_s2_ff;
            end
        end
    end

    // ----------------------------------------------------------------
    // register read, data one cycle after the strobe
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] rmux;

    always_comb begin
        rmux = '0;
        unique case (addr)
            OFF_CTRL: rmux[EN_W-1:0] = enable_ff;
            OFF_TRIG: rmux[VOLT_W-1:0] = trig_ff;
            OFF_OVLV: rmux[VOLT_W-1:0] = ovlv_ff;
            OFF_TIME: rmux[TIME_W-1:0] = time_ff;
            OFF_STEP: rmux[STEP_W-1:0] = step_ff;
            OFF_STAT: rmux[EV_W-1:0] = status_ff;
            OFF_MASK: rmux[EV_W-1:0] = mask_ff;
            OFF_MON: begin
                rmux[FREQ_W-1:0] = freq_out;
                rmux[MON_STATE_LSB +: 2] = state_ff;
                rmux[MON_PAUSE_BIT] = ramp_paused;
                rmux[MON_DRIVE_BIT] = drive_en;
            end
            default: rmux = '0;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata <= '0;
        end else begin
            rdata <= rd ? rmux : '0;
        end
    end

endmodule

// file: testbench/pld_load_model.sv
/*
 * Motor load and dc bus measurement model.
 * Assumes the bench steers mains and the bus target; the bus slews to it.
 */
`timescale 1ns/1ps
module pld_load_model
    import pld_pkg::*;
#(
    parameter int UV_LEVEL = 200,
    parameter int SLEW = 8
) (
    input logic clock,
    input logic rstn,
    input logic mains_on,
    input logic [pld_pkg::VOLT_W-1:0] tgt_volt,
    output logic [pld_pkg::VOLT_W-1:0] bus_volt,
    output logic power_ok_pin,
    output logic uv_pin
);
    logic [VOLT_W-1:0] bus_ff;
    logic [VOLT_W-1:0] aim;

    // mains pins the bus at nominal
    assign aim = mains_on ? 14'h0bb8 : tgt_volt;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bus_ff <= 14'h0bb8;
        end else if (bus_ff + VOLT_W'(SLEW) < aim) begin
            bus_ff <= bus_ff + VOLT_W'(SLEW);
        end else if (bus_ff > aim + VOLT_W'(SLEW)) begin
            bus_ff <= bus_ff - VOLT_W'(SLEW);
        end else begin
            bus_ff <= aim;
        end
    end

    assign bus_volt = bus_ff;
    assign power_ok_pin = mains_on;
    assign uv_pin = bus_ff < VOLT_W'(UV_LEVEL);
endmodule

// file: testbench/pld_monitor.sv
/*
 * Port checker bound into pld_top.
 * Assumes levels change only by register writes.
 */
`timescale 1ns/1ps
module pld_top_monitor
    import pld_pkg::*;
(
    input logic clock,
    input logic rstn,
    input logic [pld_pkg::ADDR_W-1:0] addr,
    input logic [pld_pkg::DATA_W-1:0] wdata,
    input logic wr,
    input logic rd,
    input logic [pld_pkg::DATA_W-1:0] rdata,
    input logic [pld_pkg::VOLT_W-1:0] bus_volt,
    input logic [pld_pkg::FREQ_W-1:0] freq_out,
    input logic drive_en,
    input logic decel_active,
    input logic ramp_paused,
    input logic run_permit,
    input logic pf_ind,
    input logic uv_ind,
    input logic irq
);
    // ----------------------------------------------------------------
    // shadow of written levels
    // ----------------------------------------------------------------
    logic [VOLT_W-1:0] trig_ff;
    logic [VOLT_W-1:0] ovlv_ff;
    logic [STEP_W-1:0] step_ff;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            trig_ff <= TRIG_RST;
            ovlv_ff <= OVLV_RST;
            step_ff <= STEP_RST;
        end else if (wr) begin
            if (addr == OFF_TRIG) trig_ff <= wdata[VOLT_W-1:0];
            if (addr == OFF_OVLV) ovlv_ff <= wdata[VOLT_W-1:0];
            if (addr == OFF_STEP) step_ff <= (wdata > STEP_MAX) ? 10'h3e8 : wdata[STEP_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("rdata off cycle");
    coast_zero_a: assert property (!drive_en |-> freq_out == 16'h0)
        else $error("freq while off");
    entry_level_a: assert property ($rose(decel_active) |-> $past(bus_volt, 2) <= trig_ff)
        else $error("start above trigger");
    entry_step_a: assert property ($rose(decel_active) && $past(freq_out, 2) >= 16'(step_ff)
        |-> $past(freq_out) + 16'(step_ff) == $past(freq_out, 2))
        else $error("initial step wrong");
    ramp_down_a: assert property (decel_active && $past(decel_active)
        |-> freq_out <= $past(freq_out))
        else $error("freq rose in stop");
    pause_hold_a: assert property (ramp_paused && $past(ramp_paused) && decel_active
        |-> $stable(freq_out))
        else $error("freq moved in pause");
    pause_cause_a: assert property (ramp_paused |-> $past(bus_volt) > ovlv_ff)
        else $error("pause without overvolt");
    pf_flag_a: assert property (decel_active |-> pf_ind)
        else $error("pf low in stop");
    uv_flag_a: assert property (decel_active |-> !uv_ind)
        else $error("uv flag in stop");
    permit_mode_a: assert property (run_permit |-> !decel_active && drive_en)
        else $error("permit in stop");

    cov_start: cover property ($rose(decel_active));
    cov_pause: cover property ($rose(ramp_paused));
    cov_halt: cover property ($fell(drive_en) && decel_active);
    cov_irq: cover property ($rose(irq));
endmodule

bind pld_top pld_top_monitor pld_top_monitor_i (
    .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .bus_volt(bus_volt), .freq_out(freq_out), .drive_en(drive_en),
    .decel_active(decel_active), .ramp_paused(ramp_paused), .run_permit(run_permit),
    .pf_ind(pf_ind), .uv_ind(uv_ind), .irq(irq)
);

// file: testbench/tb_top.sv
/*
 * Self-checking bench for pld_top and the load model.
 * Assumes a short tick so ramps stay short.
 */
`timescale 1ns/1ps
module tb_top;
    import pld_pkg::*;
    logic clock, rstn, wr, rd, mains_on, power_ok_pin, uv_pin;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [FREQ_W-1:0] freq_ref, freq_out, prev_f, held_f;
    logic [VOLT_W-1:0] bus_volt, tgt_volt;
    logic drive_en, decel_active, ramp_paused, run_permit, pf_ind, uv_ind, irq;
    int fails, samples_checked;
    logic [FREQ_W-1:0] drops[$];

    pld_top #(.TICK_CYCLES_P(4)) pld_top_i (.clock(clock), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .freq_ref(freq_ref),
        .bus_volt(bus_volt), .power_ok_pin(power_ok_pin), .uv_pin(uv_pin),
        .freq_out(freq_out), .drive_en(drive_en), .decel_active(decel_active),
        .ramp_paused(ramp_paused), .run_permit(run_permit), .pf_ind(pf_ind),
        .uv_ind(uv_ind), .irq(irq));
    pld_load_model pld_load_model_i (.clock(clock), .rstn(rstn), .mains_on(mains_on),
        .tgt_volt(tgt_volt), .bus_volt(bus_volt), .power_ok_pin(power_ok_pin),
        .uv_pin(uv_pin));

    // ----------------------------------------------------------------
    // clock and frequency drop recorder
    // ----------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    always @(posedge clock) begin
        if (drive_en === 1'b1 && freq_out < prev_f) drops.push_back(prev_f - freq_out);
        prev_f <= freq_out;
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %h want %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string msg);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        chk(rdata, exp, msg);
    endtask

    // sel 0 decel_active, 1 drive_en, 2 ramp_paused
    task automatic wait_on(input int sel, input logic v);
        int n;
        n = 0;
        while ((sel == 0 ? decel_active : sel == 1 ? drive_en : ramp_paused) !== v
               && n < 3000) begin
            @(negedge clock);
            n++;
        end
        chk(n < 3000, 1'b1, "wait expired");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #(25 * 30000);
        fails++;
        $display("BAD %0t watchdog", $time);
        print_verdict();
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        rstn = 1'b0; wr = 1'b0; rd = 1'b0; addr = '0; wdata = '0;
        mains_on = 1'b1; tgt_volt = 14'h05dc; freq_ref = 16'h1388;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        rd_chk(OFF_CTRL, 32'h0, "ctrl reset");
        rd_chk(OFF_TIME, 32'h64, "time reset");
        rd_chk(6'h20, 32'h0, "unmapped read");
        wr_reg(OFF_STEP, 32'h7ff);
        rd_chk(OFF_STEP, 32'h3e8, "step clamp");
        $display("test reset done");

        wr_reg(OFF_TRIG, 32'h7d0);
        wr_reg(OFF_OVLV, 32'hdac);
        for (int c = 0; c < 4; c += 2) begin
            wr_reg(OFF_CTRL, c == 0 ? 32'h0 : 32'h2);
            mains_on <= 1'b0;
            wait_on(1, 1'b0);
            chk(freq_out, 16'h0, "coast freq");
            chk(pf_ind, 1'b1, "pf off");
            repeat (150) @(negedge clock);
            chk(decel_active, 1'b0, "off no stop");
            mains_on <= 1'b1;
            wait_on(1, 1'b1);
            repeat (200) @(negedge clock);
        end
        $display("test disabled done");

        wr_reg(OFF_CTRL, 32'h1);
        wr_reg(OFF_STEP, 32'h64);
        wr_reg(OFF_TIME, 32'h4);
        wr_reg(OFF_MASK, 32'h9);
        repeat (10) @(negedge clock);
        drops.delete();
        mains_on <= 1'b0;
        repeat (100) @(negedge clock);
        chk(freq_out, 16'h1388, "pre-trigger");
        wait_on(0, 1'b1);
        mains_on <= 1'b1;
        wait_on(1, 1'b0);
        chk(drops.size(), 5, "drop count");
        chk(drops[0], 16'h64, "initial step");
        for (int k = 1; k < 5; k++) chk(drops[k], 16'h4c9, "ramp slope");
        wait_on(1, 1'b1);
        repeat (3) @(negedge clock);
        chk(run_permit, 1'b1, "run mode back");
        rd_chk(OFF_STAT, 32'h9, "events");
        chk(irq, 1'b1, "irq raised");
        wr_reg(OFF_STAT, 32'h9);
        @(negedge clock);
        chk(irq, 1'b0, "irq cleared");
        $display("test ramp done");

        wr_reg(OFF_MASK, 32'h0);
        wr_reg(OFF_STEP, 32'h0);
        wr_reg(OFF_TIME, 32'h1f4);
        wr_reg(OFF_OVLV, 32'h9c4);
        mains_on <= 1'b0;
        wait_on(0, 1'b1);
        for (int p = 0; p < 2; p++) begin
            tgt_volt <= 14'h0a8c;
            wait_on(2, 1'b1);
            held_f = freq_out;
            repeat (30) @(negedge clock);
            chk(freq_out, held_f, "hold");
            tgt_volt <= 14'h05dc;
            wait_on(2, 1'b0);
            repeat (30) @(negedge clock);
            chk(freq_out < held_f, 1'b1, "ramp resumed");
        end
        tgt_volt <= 14'h0;
        wait_on(1, 1'b0);
        chk(freq_out, 16'h0, "uv halt freq");
        rd_chk(OFF_STAT, 32'h7, "uv events");
        chk(irq, 1'b0, "irq masked");
        mains_on <= 1'b1;
        wait_on(1, 1'b1);
        repeat (3) @(negedge clock);
        chk(run_permit, 1'b1, "run after uv");
        $display("test pause done");
        print_verdict();
    end
endmodule
